// *** tcaod_map.vh ***
`ifndef TCAOD_MAP_VH
`define TCAOD_MAP_VH
// Register byte offsets
`define TCAOD_CTRL_OFS 8'h00
`define TCAOD_STAT_OFS 8'h04
`define TCAOD_ILIM_OFS 8'h08
`define TCAOD_ISNS_OFS 8'h0C
// Control fields
`define TCAOD_CTRL_ROLE 0
`define TCAOD_CTRL_ADV_LO 1
`define TCAOD_CTRL_APP 3
`define TCAOD_CTRL_PDDIS 4
`define TCAOD_CTRL_SWEN 5
`define TCAOD_CTRL_RST 32'h00000000
`define TCAOD_ILIM_RST 12'hFFF
// Line class codes
`define TCAOD_LN_OPEN 2'h0
`define TCAOD_LN_RD 2'h1
`define TCAOD_LN_RA 2'h2
// Advertisement codes
`define TCAOD_ADV_DEF 2'h0
`define TCAOD_ADV_1P5 2'h1
`define TCAOD_ADV_3P0 2'h2
`endif

// *** tcaod_top.v ***
// What this block does
// - Source, both lines open: watch both, VBUS and VCONN stay off.
// - Source, Rd on A, B open: attached on A, VBUS on, watch A.
// - Source, Rd on B, A open: attached on B, VBUS on, watch B.
// - Source, Ra and open: powered cable, no power, watch both lines.
// - Source, Ra and Rd: VBUS on, VCONN to Ra line, watch Rd only.
// - Source drives pull-up current per line, classifies each line alone.
// - Source advertisement default, 1.5 A or 3 A picks current and thresholds.
// - Line below active cable threshold is classed as Ra needing VCONN.
// - Connected line rising above sink detect threshold means detach.
// - Sink presents trimmed pull-down on both lines, waits for pull-up.
// - Sink attach is decided from VBUS presence.
// - Sink derives partner capability from seen pull-up level.
// - Untrimmed pull-down until application runs, then trimmed.
// - Sink pull-down can be disabled while acting as source.
// - Five volt path only sources; reverse current limited while on.
// - Five volt path current readable through the converter.
// - Path limit activates when current exceeds configured limit while on.
`default_nettype none
`include "tcaod_map.vh"
module tcaod_top #(
	parameter ADC_W = 12
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Analog comparator results per line
	input wire line_a_below_sink_detect,
	input wire line_a_below_active_cable,
	input wire line_b_below_sink_detect,
	input wire line_b_below_active_cable,
	input wire [1:0] line_a_pullup_level,
	input wire [1:0] line_b_pullup_level,
	input wire vbus_present,
	// Five volt path sense
	input wire [ADC_W-1:0] five_volt_path_current,
	input wire five_volt_reverse_detect,
	// Analog controls
	output reg [1:0] source_pullup_current,
	output reg [1:0] sink_detect_threshold,
	output reg [1:0] active_cable_threshold,
	output reg source_pullup_en,
	output reg trimmed_sink_pulldown,
	output reg untrimmed_deadbatt_pulldown,
	output reg vbus_5v_en,
	output reg vconn_a_en,
	output reg vconn_b_en,
	output reg five_volt_path_limit,
	output reg five_volt_reverse_block,
	// Attach status
	output reg attached,
	output reg orientation_b,
	output reg cable_present
);
	// ****************************************
	// Attach states
	// ****************************************
	localparam ST_OPEN = 3'd0;
	localparam ST_UFP_A = 3'd1;
	localparam ST_UFP_B = 3'd2;
	localparam ST_CBL_A = 3'd3;
	localparam ST_CBL_B = 3'd4;
	localparam ST_FULL_A = 3'd5;
	localparam ST_FULL_B = 3'd6;
	localparam ST_SINK = 3'd7;

	function [1:0] classify;
		input below_rd;
		input below_ra;
		begin
			if (below_ra)
				classify = `TCAOD_LN_RA;
			else if (below_rd)
				classify = `TCAOD_LN_RD;
			else
				classify = `TCAOD_LN_OPEN;
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	reg [31:0] ctrl_reg;
	reg [ADC_W-1:0] ilim_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [1:0] cls_a;
	reg [1:0] cls_b;
	reg [1:0] partner_adv_reg;
	reg [7:0] aw_addr_reg;
	reg aw_held_reg;
	reg w_held_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire role_src;
	wire [1:0] adv;
	wire do_write;
	integer i;

	assign role_src = ctrl_reg[`TCAOD_CTRL_ROLE];
	assign adv = ctrl_reg[`TCAOD_CTRL_ADV_LO+1:`TCAOD_CTRL_ADV_LO];
	assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

	// ****************************************
	// Line classification and next state
	// ****************************************
	always @*
	begin
		cls_a = classify(line_a_below_sink_detect,
			line_a_below_active_cable);
		cls_b = classify(line_b_below_sink_detect,
			line_b_below_active_cable);
		state_next = state_reg;
		if (!role_src)
			state_next = ST_SINK;
		else
			case (state_reg)
				ST_OPEN, ST_SINK, ST_CBL_A, ST_CBL_B:
				begin
					// Re-evaluated every cycle; detach returns to open
					if (cls_a == `TCAOD_LN_RD && cls_b == `TCAOD_LN_OPEN)
						state_next = ST_UFP_A;
					else if (cls_b == `TCAOD_LN_RD &&
						cls_a == `TCAOD_LN_OPEN)
						state_next = ST_UFP_B;
					else if (cls_a == `TCAOD_LN_RA &&
						cls_b == `TCAOD_LN_RD)
						state_next = ST_FULL_B;
					else if (cls_b == `TCAOD_LN_RA &&
						cls_a == `TCAOD_LN_RD)
						state_next = ST_FULL_A;
					else if (cls_a == `TCAOD_LN_RA)
						state_next = ST_CBL_A;
					else if (cls_b == `TCAOD_LN_RA)
						state_next = ST_CBL_B;
					else
						state_next = ST_OPEN;
				end
				ST_UFP_A, ST_FULL_A:
					if (!line_a_below_sink_detect)
						state_next = ST_OPEN;
				ST_UFP_B, ST_FULL_B:
					if (!line_b_below_sink_detect)
						state_next = ST_OPEN;
				default:
					state_next = ST_OPEN;
			endcase
	end

	// ****************************************
	// Attach state and analog controls
	// ****************************************
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_SINK;
			source_pullup_current <= `TCAOD_ADV_DEF;
			sink_detect_threshold <= `TCAOD_ADV_DEF;
			active_cable_threshold <= `TCAOD_ADV_DEF;
			source_pullup_en <= 1'b0;
			trimmed_sink_pulldown <= 1'b0;
			untrimmed_deadbatt_pulldown <= 1'b1;
			vbus_5v_en <= 1'b0;
			vconn_a_en <= 1'b0;
			vconn_b_en <= 1'b0;
			five_volt_path_limit <= 1'b0;
			five_volt_reverse_block <= 1'b0;
			attached <= 1'b0;
			orientation_b <= 1'b0;
			cable_present <= 1'b0;
			partner_adv_reg <= `TCAOD_ADV_DEF;
		end
		else
		begin
			state_reg <= state_next;
			source_pullup_current <= adv;
			sink_detect_threshold <= adv;
			active_cable_threshold <= adv;
			source_pullup_en <= role_src;
			// Dead-battery pull-down until application code takes over
			untrimmed_deadbatt_pulldown <= ~ctrl_reg[`TCAOD_CTRL_APP] &
				~(role_src & ctrl_reg[`TCAOD_CTRL_PDDIS]);
			trimmed_sink_pulldown <= ctrl_reg[`TCAOD_CTRL_APP] &
				~(role_src & ctrl_reg[`TCAOD_CTRL_PDDIS]);
			vbus_5v_en <= ctrl_reg[`TCAOD_CTRL_SWEN] & role_src &
				(state_next == ST_UFP_A || state_next == ST_UFP_B ||
				state_next == ST_FULL_A ||
				state_next == ST_FULL_B);
			vconn_a_en <= ctrl_reg[`TCAOD_CTRL_SWEN] &
				(state_next == ST_FULL_B);
			vconn_b_en <= ctrl_reg[`TCAOD_CTRL_SWEN] &
				(state_next == ST_FULL_A);
			five_volt_path_limit <= vbus_5v_en &
				(five_volt_path_current > ilim_reg);
			five_volt_reverse_block <= vbus_5v_en &
				five_volt_reverse_detect;
			cable_present <= (state_next == ST_CBL_A ||
				state_next == ST_CBL_B || state_next == ST_FULL_A ||
				state_next == ST_FULL_B);
			if (state_next == ST_SINK)
			begin
				attached <= vbus_present;
				if (line_b_pullup_level > line_a_pullup_level)
				begin
					partner_adv_reg <= line_b_pullup_level;
					orientation_b <= 1'b1;
				end
				else
				begin
					partner_adv_reg <= line_a_pullup_level;
					orientation_b <= 1'b0;
				end
			end
			else
			begin
				attached <= (state_next == ST_UFP_A ||
					state_next == ST_UFP_B || state_next == ST_FULL_A ||
					state_next == ST_FULL_B);
				orientation_b <= (state_next == ST_UFP_B ||
					state_next == ST_FULL_B);
			end
		end
	end

	// ****************************************
	// AXI4-Lite write
	// ****************************************
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			ctrl_reg <= `TCAOD_CTRL_RST;
			ilim_reg <= `TCAOD_ILIM_RST;
		end
		else
		begin
			s_axi_awready <= ~aw_held_reg & ~s_axi_awready;
			s_axi_wready <= ~w_held_reg & ~s_axi_wready;
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case ({aw_addr_reg[7:2], 2'b00})
					`TCAOD_CTRL_OFS:
						for (i = 0; i < 4; i = i + 1)
							if (w_strb_reg[i])
								ctrl_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
					`TCAOD_ILIM_OFS:
					begin
						if (w_strb_reg[0])
							ilim_reg[7:0] <= w_data_reg[7:0];
						if (w_strb_reg[1])
							ilim_reg[ADC_W-1:8] <= w_data_reg[ADC_W-1:8];
					end
					`TCAOD_STAT_OFS, `TCAOD_ISNS_OFS:
						s_axi_bresp <= 2'h0;
					default:
						s_axi_bresp <= 2'h2;
				endcase
			end
			if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read
	// ****************************************
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else
		begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				s_axi_rdata <= 32'h00000000;
				case ({s_axi_araddr[7:2], 2'b00})
					`TCAOD_CTRL_OFS:
						s_axi_rdata <= ctrl_reg;
					`TCAOD_STAT_OFS:
						s_axi_rdata <= {20'h00000, partner_adv_reg,
							five_volt_path_limit, vconn_b_en, vconn_a_en,
							vbus_5v_en, cable_present, orientation_b,
							attached, state_reg};
					`TCAOD_ILIM_OFS:
						s_axi_rdata <= {{(32-ADC_W){1'b0}}, ilim_reg};
					`TCAOD_ISNS_OFS:
						s_axi_rdata <= {{(32-ADC_W){1'b0}},
							five_volt_path_current};
					default:
						s_axi_rresp <= 2'h2;
				endcase
			end
			if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // tcaod_top
`default_nettype wire

// *** tcaod_far.sv ***
`default_nettype none
`include "tcaod_map.vh"
// ****
// Attached partner line loads
// ****
module tcaod_far (
	// Source pull-up and far loads
	input wire logic pu_en,
	input wire logic [1:0] kind_a,
	input wire logic [1:0] kind_b,
	// Comparator results
	output logic a_sd,
	output logic a_ra,
	output logic b_sd,
	output logic b_ra
);
	timeunit 1ns;
	timeprecision 1ps;
	// A load shows only while the pull-up current flows
	assign a_sd = pu_en && kind_a != `TCAOD_LN_OPEN;
	assign b_sd = pu_en && kind_b != `TCAOD_LN_OPEN;
	assign a_ra = pu_en && kind_a == `TCAOD_LN_RA;
	assign b_ra = pu_en && kind_b == `TCAOD_LN_RA;
endmodule // tcaod_far
`default_nettype wire

// *** tcaod_chk_asserts.sv ***
`default_nettype none
// ****
// Port checker
// ****
module tcaod_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Inputs
	input wire logic line_a_below_sink_detect,
	input wire logic line_a_below_active_cable,
	input wire logic line_b_below_sink_detect,
	input wire logic line_b_below_active_cable,
	input wire logic vbus_present,
	input wire logic five_volt_reverse_detect,
	// Outputs
	input wire logic [1:0] source_pullup_current,
	input wire logic [1:0] sink_detect_threshold,
	input wire logic [1:0] active_cable_threshold,
	input wire logic source_pullup_en,
	input wire logic vbus_5v_en,
	input wire logic vconn_a_en,
	input wire logic vconn_b_en,
	input wire logic five_volt_reverse_block,
	input wire logic attached,
	input wire logic orientation_b,
	input wire logic cable_present
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire s = source_pullup_en;
	wire ad = line_a_below_sink_detect;
	wire ar = line_a_below_active_cable;
	wire bd = line_b_below_sink_detect;
	wire br = line_b_below_active_cable;
	property p_idle;
		(s && !ad && !bd) [*3] |-> !vbus_5v_en && !vconn_a_en && !vconn_b_en;
	endproperty
	a_idle: assert property (p_idle) else $error("power while open");
	property p_ufpa;
		(s && ad && !ar && !bd) [*3] |-> attached && !orientation_b;
	endproperty
	a_ufpa: assert property (p_ufpa) else $error("no attach a");
	property p_ufpb;
		(s && bd && !br && !ad) [*3] |-> attached && orientation_b;
	endproperty
	a_ufpb: assert property (p_ufpb) else $error("no attach b");
	property p_cab;
		(s && ar && !bd) [*3] |-> cable_present && !attached && !vconn_a_en;
	endproperty
	a_cab: assert property (p_cab) else $error("bad cable state");
	property p_pow;
		(s && ar && bd && !br) [*3] |-> vconn_a_en && !vconn_b_en && attached;
	endproperty
	a_pow: assert property (p_pow) else $error("bad vconn");
	property p_adv;
		sink_detect_threshold == source_pullup_current
			&& active_cable_threshold == source_pullup_current;
	endproperty
	a_adv: assert property (p_adv) else $error("level mismatch");
	property p_rev;
		five_volt_reverse_block == $past(vbus_5v_en && five_volt_reverse_detect);
	endproperty
	a_rev: assert property (p_rev) else $error("reverse block");
	property p_snk;
		(!s && $stable(vbus_present)) [*3] |-> attached == vbus_present;
	endproperty
	a_snk: assert property (p_snk) else $error("sink attach");
endmodule // tcaod_chk
bind tcaod_top tcaod_chk u_chk (.sys_clk, .rst, .line_a_below_sink_detect,
	.line_a_below_active_cable, .line_b_below_sink_detect,
	.line_b_below_active_cable, .vbus_present, .five_volt_reverse_detect,
	.source_pullup_current, .sink_detect_threshold, .active_cable_threshold,
	.source_pullup_en, .vbus_5v_en, .vconn_a_en, .vconn_b_en,
	.five_volt_reverse_block, .attached, .orientation_b, .cable_present);
`default_nettype wire

// *** tcaod_tb.sv ***
`default_nettype none
`include "tcaod_map.vh"
// ****
// Testbench
// ****
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, ka = 2'h0, kb = 2'h0;
	logic [1:0] line_a_pullup_level = 2'h0, line_b_pullup_level = 2'h0;
	logic s_axi_rvalid, vbus_present = 0, five_volt_reverse_detect = 0;
	logic [11:0] five_volt_path_current = 12'h000;
	logic line_a_below_sink_detect, line_a_below_active_cable;
	logic line_b_below_sink_detect, line_b_below_active_cable;
	logic [1:0] source_pullup_current, sink_detect_threshold;
	logic [1:0] active_cable_threshold;
	logic source_pullup_en, trimmed_sink_pulldown, untrimmed_deadbatt_pulldown;
	logic vbus_5v_en, vconn_a_en, vconn_b_en, five_volt_path_limit;
	logic five_volt_reverse_block, attached, orientation_b, cable_present;
	int err_count = 0, total_checks = 0;
	logic [1:0] tka [7] = '{0, 1, 0, 2, 0, 2, 1};
	logic [1:0] tkb [7] = '{0, 0, 1, 0, 2, 1, 2};
	logic [4:0] tex [7] = '{0, 5'h14, 5'h14, 5'h08, 5'h08, 5'h1E, 5'h1D};
	logic tor [7] = '{0, 0, 1, 0, 0, 1, 0};
	always #2.5 sys_clk = ~sys_clk;
	tcaod_top dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_a_below_sink_detect,
		.line_a_below_active_cable, .line_b_below_sink_detect,
		.line_b_below_active_cable, .line_a_pullup_level, .line_b_pullup_level,
		.vbus_present, .five_volt_path_current, .five_volt_reverse_detect,
		.source_pullup_current, .sink_detect_threshold, .active_cable_threshold,
		.source_pullup_en, .trimmed_sink_pulldown, .untrimmed_deadbatt_pulldown,
		.vbus_5v_en, .vconn_a_en, .vconn_b_en, .five_volt_path_limit,
		.five_volt_reverse_block, .attached, .orientation_b, .cable_present);
	tcaod_far far (.pu_en(source_pullup_en), .kind_a(ka), .kind_b(kb),
		.a_sd(line_a_below_sink_detect), .a_ra(line_a_below_active_cable),
		.b_sd(line_b_below_sink_detect), .b_ra(line_b_below_active_cable));
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task to(input int n);
		if (n >= 50)
		begin
			err_count++;
			report_and_stop;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready === 1) s_axi_awvalid <= 0;
			if (s_axi_wready === 1) s_axi_wvalid <= 0;
			n++;
		end while ((s_axi_awvalid && s_axi_awready !== 1 ||
			s_axi_wvalid && s_axi_wready !== 1) && n < 50);
		s_axi_bready <= 1;
		do cyc(1); while (s_axi_bvalid !== 1 && n++ < 50);
		rr = s_axi_bresp;
		s_axi_bready <= 0;
		to(n);
	endtask
	task rda(input logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready === 1) s_axi_arvalid <= 0;
			n++;
		end while (s_axi_arready !== 1 && n < 50);
		s_axi_rready <= 1;
		do cyc(1); while (s_axi_rvalid !== 1 && n++ < 50);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		to(n);
	endtask
	initial
	begin
		cyc(2);
		rst <= 0;
		cyc(1);
		chk("deadbatt pd", 1, untrimmed_deadbatt_pulldown);
		rda(`TCAOD_CTRL_OFS);
		chk("ctrl", `TCAOD_CTRL_RST, rd);
		rda(`TCAOD_ILIM_OFS);
		chk("ilim", `TCAOD_ILIM_RST, rd);
		rda(8'h10);
		chk("rd resp", 2'h2, rr);
		wr(8'h10, 32'h0);
		chk("wr resp", 2'h2, rr);
		wr(`TCAOD_STAT_OFS, 32'hFFF);
		chk("stat wr resp", 2'h0, rr);
		wr(`TCAOD_CTRL_OFS, 32'h08);
		cyc(2);
		chk("trim pd", 2'h2,
			{trimmed_sink_pulldown, untrimmed_deadbatt_pulldown});
		$display("test reset done");
		line_a_pullup_level <= 2'h1;
		line_b_pullup_level <= 2'h2;
		vbus_present <= 1;
		cyc(3);
		chk("sink attach", 2'h3, {attached, orientation_b});
		rda(`TCAOD_STAT_OFS);
		chk("partner adv", 2'h2, rd[11:10]);
		vbus_present <= 0;
		cyc(3);
		chk("sink detach", 0, attached);
		$display("test sink done");
		for (int v = 0; v < 3; v++)
		begin
			wr(`TCAOD_CTRL_OFS, 32'h29 | (v << 1));
			cyc(2);
			chk("adv", v + 4, {source_pullup_en, source_pullup_current});
			chk("thr", {v[1:0], v[1:0]},
				{sink_detect_threshold, active_cable_threshold});
		end
		for (int i = 0; i < 7; i++)
		begin
			ka <= tka[i];
			kb <= tkb[i];
			cyc(4);
			chk("state", tex[i], {attached, cable_present, vbus_5v_en,
				vconn_a_en, vconn_b_en});
			if (tex[i][4]) chk("orient", tor[i], orientation_b);
			ka <= 2'h0;
			kb <= 2'h0;
			cyc(4);
			chk("detach", 0, {attached, vbus_5v_en, vconn_a_en});
		end
		$display("test source done");
		ka <= 2'h1;
		five_volt_path_current <= 12'h101;
		wr(`TCAOD_ILIM_OFS, 32'h100);
		cyc(3);
		chk("limit", 1, five_volt_path_limit);
		rda(`TCAOD_ISNS_OFS);
		chk("sense", 32'h101, rd);
		five_volt_path_current <= 12'h100;
		five_volt_reverse_detect <= 1;
		cyc(3);
		chk("limit rev", 2'h1,
			{five_volt_path_limit, five_volt_reverse_block});
		wr(`TCAOD_CTRL_OFS, 32'h39);
		cyc(2);
		chk("pd off", 0, trimmed_sink_pulldown);
		$display("test power done");
		report_and_stop;
	end
endmodule // testbench
`default_nettype wire
